// *** logic/cobc_regs.sv ***
// Output driver and bias control register group of the codec.
// Assumes the control-bus decoder presents single-cycle read and write
// strobes with an 8-bit register address, all synchronous to mclk.
`timescale 1ns/1ps

// Behaviour
// - Speaker gain code 00..11 selects 6, 12, 18, 24 dB.
// - Speaker unmute bit zero mutes the right speaker driver.
// - Applied flag reads zero until the driven gain reaches the programmed one.
// - Debounce code 000..111 gives 0 to 512 us from 1 MHz ticks.
// - Debounce tick period is one eighth of the selected duration.
// - Oscillator source uses 8.2 MHz oscillator, times scale with it.
// - DAC current mode 00, 01, 11; code 10 reserved.
// - Left headphone mode bit: zero headphone, one line-out.
// - Right headphone mode bit: zero headphone, one line-out.
// - Bias register top bit enables device software power-down.
// - Force bit powers bias even with detection on and no headset.
// - Bias level 00 off, 01 2 V, 10 2.5 V, 11 analog supply.
module cobc_regs #(
  parameter int STEP_CYCLES = cobc_pkg::GAIN_STEP_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register access port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Right speaker driver
  output logic [1:0] right_speaker_output_gain,
  output logic right_speaker_output_unmute,
  // Headphone drivers and DAC
  output logic [1:0] dac_current_mode,
  output logic left_headphone_output_lineout,
  output logic right_headphone_output_lineout,
  // Headset short detection
  input wire logic div_tick,
  input wire logic osc_tick,
  input wire logic debounce_use_osc,
  input wire logic headset_short_detect,
  output logic headset_short_flag,
  // Microphone bias and power
  input wire logic headset_detect_en,
  input wire logic headset_present,
  output logic sw_powerdown,
  output logic microphone_bias_enable,
  output logic [1:0] microphone_bias_level
);

  localparam int STEP_W = $clog2(STEP_CYCLES + 1);

  logic [7:0] spk_reg;
  logic [7:0] hp_reg;
  logic [7:0] bias_reg;
  logic [1:0] gain_now_reg;
  logic [STEP_W-1:0] step_cnt_reg;
  logic [7:0] rdata_reg;
  logic unmute_reg;
  logic [1:0] dac_reg;
  logic left_line_reg;
  logic right_line_reg;
  logic pdn_reg;
  logic bias_en_reg;
  logic [1:0] bias_lvl_reg;

  // Address decode
  wire sel_spk = reg_addr == cobc_pkg::SPK_R_OFFSET;
  wire sel_hp = reg_addr == cobc_pkg::HP_CTRL_OFFSET;
  wire sel_bias = reg_addr == cobc_pkg::BIAS_OFFSET;
  wire wr_spk = reg_wr && sel_spk;
  wire wr_hp = reg_wr && sel_hp;
  wire wr_bias = reg_wr && sel_bias;

  // Field extraction
  wire [1:0] gain_target = spk_reg[cobc_pkg::SPK_GAIN_LSB +: 2];
  wire [2:0] deb_sel = hp_reg[cobc_pkg::HP_DEB_LSB +: 3];
  wire [1:0] dac_code = hp_reg[cobc_pkg::HP_DAC_LSB +: 2];
  wire [1:0] lvl_code = bias_reg[cobc_pkg::BIAS_LVL_LSB +: 2];
  wire force_bias = bias_reg[cobc_pkg::BIAS_FORCE_BIT];

  // Gains applied once the driven code matches the target
  wire gain_applied = gain_now_reg == gain_target;
  wire step_due = step_cnt_reg == STEP_W'(STEP_CYCLES - 1);

  // Gain moves one 6 dB step per dwell toward the target
  wire [1:0] gain_step = (gain_now_reg < gain_target) ?
                         gain_now_reg + 2'h1 : gain_now_reg - 2'h1;

  // Read multiplexer; unmapped and reserved addresses read zero
  wire [7:0] spk_view = {spk_reg[7:1], gain_applied};
  wire [7:0] rd_mux = sel_spk ? spk_view :
                      sel_hp ? hp_reg :
                      sel_bias ? bias_reg : 8'h00;

  // Bias held off with detection on and no headset, unless forced
  wire headset_ok = force_bias || !headset_detect_en || headset_present;

  // Level code 00 powers the bias down
  wire bias_on = (lvl_code != cobc_pkg::BIAS_OFF) && headset_ok;

  // Reserved DAC code falls back to default operation
  wire [1:0] dac_next = (dac_code == cobc_pkg::DAC_RSVD) ?
                        cobc_pkg::DAC_DEFAULT : dac_code;

  // Right speaker register; reserved bits masked off
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) spk_reg <= cobc_pkg::SPK_R_RESET;
    else if (wr_spk) spk_reg <= reg_wdata & cobc_pkg::SPK_R_WMASK;
  end

  // Headphone control register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) hp_reg <= cobc_pkg::HP_CTRL_RESET;
    else if (wr_hp) hp_reg <= reg_wdata & cobc_pkg::HP_CTRL_WMASK;
  end

  // Bias register; reserved bits masked off
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) bias_reg <= cobc_pkg::BIAS_RESET;
    else if (wr_bias) bias_reg <= reg_wdata & cobc_pkg::BIAS_WMASK;
  end

  // Reserved location has no storage; writes there are dropped

  // Dwell counter between gain steps
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) step_cnt_reg <= '0;
    else if (gain_applied || step_due) step_cnt_reg <= '0;
    else step_cnt_reg <= step_cnt_reg + STEP_W'(1);
  end

  // Driven gain code walks toward the programmed code
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) gain_now_reg <= cobc_pkg::GAIN_6DB;
    else if (!gain_applied && step_due) gain_now_reg <= gain_step;
  end

  // Read data register, loaded on a read strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) rdata_reg <= 8'h00;
    else if (reg_rd) rdata_reg <= rd_mux;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) unmute_reg <= 1'b0;
    else unmute_reg <= spk_reg[cobc_pkg::SPK_UNMUTE_BIT];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) dac_reg <= cobc_pkg::DAC_DEFAULT;
    else dac_reg <= dac_next;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) left_line_reg <= 1'b0;
    else left_line_reg <= hp_reg[cobc_pkg::HP_LEFT_LINE_BIT];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) right_line_reg <= 1'b0;
    else right_line_reg <= hp_reg[cobc_pkg::HP_RIGHT_LINE_BIT];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) pdn_reg <= 1'b0;
    else pdn_reg <= bias_reg[cobc_pkg::BIAS_PDN_BIT];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) bias_en_reg <= 1'b0;
    else bias_en_reg <= bias_on;
  end

  // Bias level select, forced to off when disabled
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) bias_lvl_reg <= cobc_pkg::BIAS_OFF;
    else bias_lvl_reg <= bias_on ? lvl_code : cobc_pkg::BIAS_OFF;
  end

  // Debounce timer; oscillator or divided clock as base
  cobc_debounce #(
    .TICKS(cobc_pkg::DEB_TICKS),
    .PRESCALE(cobc_pkg::OSC_PRESCALE)
  ) u_debounce (
    .mclk(mclk),
    .rst(rst),
    .div_tick(div_tick),
    .osc_tick(osc_tick),
    .use_osc(debounce_use_osc),
    .deb_sel(deb_sel),
    .detect(headset_short_detect),
    .short_flag(headset_short_flag)
  );

  // Output drive
  assign reg_rdata = rdata_reg;
  assign right_speaker_output_gain = gain_now_reg;
  assign right_speaker_output_unmute = unmute_reg;
  assign dac_current_mode = dac_reg;
  assign left_headphone_output_lineout = left_line_reg;
  assign right_headphone_output_lineout = right_line_reg;
  assign sw_powerdown = pdn_reg;
  assign microphone_bias_enable = bias_en_reg;
  assign microphone_bias_level = bias_lvl_reg;

endmodule // cobc_regs

// *** inc/cobc_pkg.sv ***
// Constants for the codec output and bias control register group.
// Assumes an 8-bit register access port driven by the control-bus decoder.
package cobc_pkg;

  // Register offsets
  localparam logic [7:0] SPK_R_OFFSET = 8'h2b;
  localparam logic [7:0] HP_CTRL_OFFSET = 8'h2c;
  localparam logic [7:0] RSVD_OFFSET = 8'h2d;
  localparam logic [7:0] BIAS_OFFSET = 8'h2e;

  // Right speaker register fields
  localparam int SPK_GAIN_LSB = 3;
  localparam int SPK_UNMUTE_BIT = 2;
  localparam int SPK_APPLIED_BIT = 0;

  // Headphone control register fields
  localparam int HP_DEB_LSB = 5;
  localparam int HP_DAC_LSB = 3;
  localparam int HP_LEFT_LINE_BIT = 2;
  localparam int HP_RIGHT_LINE_BIT = 1;

  // Bias register fields
  localparam int BIAS_PDN_BIT = 7;
  localparam int BIAS_FORCE_BIT = 3;
  localparam int BIAS_LVL_LSB = 0;

  // Writable bit masks; reserved bits are not stored and read as zero
  localparam logic [7:0] SPK_R_WMASK = 8'h1c;
  localparam logic [7:0] HP_CTRL_WMASK = 8'hfe;
  localparam logic [7:0] BIAS_WMASK = 8'h8b;

  // Values after reset
  localparam logic [7:0] SPK_R_RESET = 8'h00;
  localparam logic [7:0] HP_CTRL_RESET = 8'h00;
  localparam logic [7:0] BIAS_RESET = 8'h00;

  // Gain codes, 6/12/18/24 dB
  typedef enum logic [1:0] {
    GAIN_6DB, GAIN_12DB, GAIN_18DB, GAIN_24DB
  } cobc_gain_t;

  // DAC current modes after decode
  typedef enum logic [1:0] {
    DAC_DEFAULT, DAC_BOOST, DAC_RSVD, DAC_BOOST_MORE
  } cobc_dac_t;

  // Bias levels: off, 2 V, 2.5 V, analog supply level
  typedef enum logic [1:0] {
    BIAS_OFF, BIAS_2V0, BIAS_2V5, BIAS_SUPPLY
  } cobc_bias_t;

  // Clock and timing
  localparam int MCLK_PERIOD_NS = 10;
  localparam int GAIN_STEP_NS = 1000;  // Dwell per 6 dB gain step
  localparam int GAIN_STEP_CYCLES = (GAIN_STEP_NS + MCLK_PERIOD_NS - 1)
                                    / MCLK_PERIOD_NS;
  localparam int DEB_TICKS = 8;        // Ticks per debounce setting
  localparam int OSC_PRESCALE = 8;     // Oscillator cycles per base tick

endpackage

// *** logic/cobc_debounce.sv ***
// Headset short-circuit debounce timer.
// Assumes tick inputs are single-cycle pulses synchronous to mclk.
`timescale 1ns/1ps

module cobc_debounce #(
  parameter int TICKS = cobc_pkg::DEB_TICKS,
  parameter int PRESCALE = cobc_pkg::OSC_PRESCALE
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Timing sources
  input wire logic div_tick,
  input wire logic osc_tick,
  input wire logic use_osc,
  // Setting and condition
  input wire logic [2:0] deb_sel,
  input wire logic detect,
  // Result
  output logic short_flag
);

  logic [2:0] osc_cnt_reg;
  logic [6:0] pre_cnt_reg;
  logic [3:0] tick_cnt_reg;
  logic flag_reg;
  wire osc_wrap = osc_tick && (osc_cnt_reg == 3'(PRESCALE - 1));
  wire base_tick = use_osc ? osc_wrap : div_tick;
  // Base tick divided by 2^(code-1): tick period is duration / 8
  wire [6:0] pre_lim = 7'(7'h01 << (deb_sel - 3'h1)) - 7'h01;
  wire deb_tick = base_tick && (pre_cnt_reg >= pre_lim);
  wire held_full = tick_cnt_reg >= 4'(TICKS);

  // Oscillator prescaler brings the 8.2 MHz rate near the 1 MHz base
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) osc_cnt_reg <= 3'h0;
    else if (osc_tick) osc_cnt_reg <= osc_wrap ? 3'h0 : osc_cnt_reg + 3'h1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) pre_cnt_reg <= 7'h00;
    else if (!detect) pre_cnt_reg <= 7'h00;
    else if (base_tick) pre_cnt_reg <= deb_tick ? 7'h00 : pre_cnt_reg + 7'h01;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) tick_cnt_reg <= 4'h0;
    else if (!detect) tick_cnt_reg <= 4'h0;
    else if (deb_tick && !held_full) tick_cnt_reg <= tick_cnt_reg + 4'h1;
  end

  // Flag after full setting; zero setting reports at once
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) flag_reg <= 1'b0;
    else flag_reg <= detect && (deb_sel == 3'h0 || held_full);
  end

  assign short_flag = flag_reg;

endmodule // cobc_debounce

// *** testbench/cobc_host.sv ***
// Host model issuing single-cycle register strobes.
// Assumes mclk from the bench, which calls the tasks below.
`timescale 1ns/1ps
module cobc_host (
  // Clock
  input wire logic mclk,
  // Register access port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // Idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Write strobe held until the taking edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d & (a == 8'h2b ? 8'h1c : a == 8'h2e ? 8'h8b : 8'hfe);
    reg_wr <= (a != 8'h2d);
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read strobe held until the taking edge
  task rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
endmodule // cobc_host

// *** testbench/cobc_regs_assertions.sv ***
// Port checker for the output and bias register group.
// Assumes one mclk domain and an active-high asynchronous rst.
`timescale 1ns/1ps
module cobc_regs_assertions (
  // Clock, reset, access port
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Outputs and detection
  input wire logic [1:0] right_speaker_output_gain,
  input wire logic right_speaker_output_unmute,
  input wire logic [1:0] dac_current_mode,
  input wire logic headset_short_detect,
  input wire logic headset_short_flag,
  input wire logic sw_powerdown,
  input wire logic microphone_bias_enable,
  input wire logic [1:0] microphone_bias_level
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Write decodes
  wire w_spk = reg_wr && reg_addr == cobc_pkg::SPK_R_OFFSET;
  wire w_hp = reg_wr && reg_addr == cobc_pkg::HP_CTRL_OFFSET;
  wire w_bias = reg_wr && reg_addr == cobc_pkg::BIAS_OFFSET;
  property p_unmute;
    w_spk |-> ##2 right_speaker_output_unmute == $past(reg_wdata[2], 2);
  endproperty
  a_unmute: assert property (p_unmute) else $error("unmute wrong");
  property p_gain_step;
    $changed(right_speaker_output_gain) |-> right_speaker_output_gain
      == $past(right_speaker_output_gain) + 2'd1
      || right_speaker_output_gain == $past(right_speaker_output_gain) - 2'd1;
  endproperty
  a_gain_step: assert property (p_gain_step) else $error("gain jump");
  property p_dac;
    w_hp && reg_wdata[4:3] != 2'b10 |-> ##2
      dac_current_mode == $past(reg_wdata[4:3], 2);
  endproperty
  a_dac: assert property (p_dac) else $error("dac mode wrong");
  property p_pdn;
    w_bias |-> ##2 sw_powerdown == $past(reg_wdata[7], 2);
  endproperty
  a_pdn: assert property (p_pdn) else $error("powerdown wrong");
  property p_force;
    w_bias && reg_wdata[3] && reg_wdata[1:0] != 2'b00 |-> ##2
      microphone_bias_enable && microphone_bias_level == $past(reg_wdata[1:0], 2);
  endproperty
  a_force: assert property (p_force) else $error("forced bias off");
  property p_bias_off;
    w_bias && reg_wdata[1:0] == 2'b00 |-> ##2 !microphone_bias_enable[*2];
  endproperty
  a_bias_off: assert property (p_bias_off) else $error("bias on");
  property p_rsvd_rd;
    reg_rd && reg_addr == cobc_pkg::RSVD_OFFSET |=> reg_rdata == 8'h00;
  endproperty
  a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved read");
  property p_short_clr;
    !headset_short_detect |=> !headset_short_flag;
  endproperty
  a_short_clr: assert property (p_short_clr) else $error("flag stuck");
endmodule // cobc_regs_assertions

bind cobc_regs cobc_regs_assertions cobc_regs_assertions_i (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .right_speaker_output_gain(right_speaker_output_gain),
  .right_speaker_output_unmute(right_speaker_output_unmute),
  .dac_current_mode(dac_current_mode),
  .headset_short_detect(headset_short_detect),
  .headset_short_flag(headset_short_flag), .sw_powerdown(sw_powerdown),
  .microphone_bias_enable(microphone_bias_enable),
  .microphone_bias_level(microphone_bias_level));

// *** testbench/cobc_regs_tb.sv ***
// Self-checking bench for the output and bias register group.
// Assumes the host model in cobc_host and a gain dwell of two cycles.
`timescale 1ns/1ps
module cobc_regs_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, unmute, left_headphone_output, right_headphone_output, pdn, bias_en, flag;
  logic [1:0] gain, dac, lvl;
  logic rd_taken = 1'b0, div_tick = 1'b0, osc_tick = 1'b0, use_osc = 1'b0;
  logic detect = 1'b0, det_en = 1'b1, present = 1'b0;
  logic [7:0] cyc = 8'h00;
  logic [7:0] exp_q[$];
  integer seed = 37, mismatches = 0, comparisons = 0, i, k;
  always #5 mclk = ~mclk;
  cobc_host cobc_host_i (.mclk(mclk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  cobc_regs #(.STEP_CYCLES(2)) cobc_regs_i (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .right_speaker_output_gain(gain), .right_speaker_output_unmute(unmute),
    .dac_current_mode(dac), .left_headphone_output_lineout(left_headphone_output),
    .right_headphone_output_lineout(right_headphone_output), .div_tick(div_tick),
    .osc_tick(osc_tick), .debounce_use_osc(use_osc),
    .headset_short_detect(detect), .headset_short_flag(flag),
    .headset_detect_en(det_en), .headset_present(present),
    .sw_powerdown(pdn), .microphone_bias_enable(bias_en),
    .microphone_bias_level(lvl));
  // Tick sources: divider every 4 cycles, oscillator every 2
  always @(posedge mclk) begin
    cyc <= cyc + 8'h01;
    div_tick <= cyc[1:0] == 2'b11;
    osc_tick <= cyc[0];
  end
  // Read result monitor against the oldest note
  always @(posedge mclk) rd_taken <= reg_rd;
  always @(negedge mclk) if (rd_taken) chk(reg_rdata, exp_q.pop_front());
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons += 1;
    if (got !== exp) begin
      mismatches += 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    cobc_host_i.rd(a);
  endtask
  task tally_and_finish;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task expire;
    mismatches += 1;
    $display("unexpected at %0t: wait ran out", $time);
    tally_and_finish();
  endtask
  task wait_gain(input logic [1:0] g);
    for (i = 0; i < 40 && gain !== g; i++) @(posedge mclk) #1;
    if (gain !== g) expire();
  endtask
  // Debounce: low before lo cycles, high within hi more, clears on release
  task deb(input logic [2:0] c, input logic o, input int lo, input int hi);
    use_osc <= o;
    cobc_host_i.wr(8'h2c, {c, 5'h00});
    detect <= 1'b1;
    repeat (lo) @(posedge mclk);
    #1 chk(8'(flag), 8'h00);
    for (i = 0; i < hi && flag !== 1'b1; i++) @(posedge mclk) #1;
    if (flag !== 1'b1) expire();
    @(posedge mclk) detect <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk(8'(flag), 8'h00);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    // Nothing pending after reset, so the applied flag already reads one
    for (k = 8'h2b; k < 8'h2f; k++) rd(8'(k), 8'(k == 8'h2b));
    // DAC codes and headphone modes with random fields
    for (k = 0; k < 8; k++) begin
      d = (8'($random(seed)) & 8'he6) | {3'b000, 2'(k), 3'b000};
      cobc_host_i.wr(8'h2c, d);
      rd(8'h2c, d);
      #1 chk(8'(dac), {6'h00, d[4:3] == 2'b10 ? 2'b00 : d[4:3]});
      chk({6'h00, left_headphone_output, right_headphone_output}, {6'h00, d[2:1]});
    end
    // Gain ramp with pending flag, then mute and a lower gain
    cobc_host_i.wr(8'h2b, 8'h1c);
    rd(8'h2b, 8'h1c);
    wait_gain(2'b11);
    rd(8'h2b, 8'h1d);
    #1 chk(8'(unmute), 8'h01);
    cobc_host_i.wr(8'h2b, 8'h08);
    wait_gain(2'b01);
    rd(8'h2b, 8'h09);
    #1 chk(8'(unmute), 8'h00);
    // Bias levels with and without force, detection on, no headset
    for (k = 0; k < 8; k++) begin
      d = (8'($random(seed)) & 8'h80) | {4'h0, k[2], 1'b0, 2'(k)};
      cobc_host_i.wr(8'h2e, d);
      rd(8'h2e, d);
      #1 chk({5'h00, pdn, bias_en, bias_en},
        {5'h00, d[7], {2{k[2] && d[1:0] != 2'b00}}});
      chk(8'(lvl), k[2] ? 8'(k[1:0]) : 8'h00);
    end
    present <= 1'b1;
    cobc_host_i.wr(8'h2e, 8'h02);
    repeat (2) @(posedge mclk);
    #1 chk({6'h00, bias_en, lvl[1]}, 8'h03);
    // Detection off: bias powers up with no headset and no force
    @(posedge mclk);
    present <= 1'b0;
    det_en <= 1'b0;
    cobc_host_i.wr(8'h2e, 8'h01);
    repeat (2) @(posedge mclk);
    #1 chk({6'h00, bias_en, lvl[0]}, 8'h03);
    deb(3'd0, 1'b0, 0, 3);
    deb(3'd1, 1'b0, 24, 16);
    deb(3'd2, 1'b0, 50, 24);
    deb(3'd1, 1'b1, 100, 40);
    tally_and_finish();
  end
endmodule // cobc_regs_tb
